// file: verilog/dtc_consts.vh
// Constants for the converter data and trigger control block
`ifndef DTC_CONSTS_VH
`define DTC_CONSTS_VH

// Per-channel register offsets, within a 32-byte channel window
`define DTC_OFF_CTRL 5'h00
`define DTC_OFF_HOLD8 5'h04
`define DTC_OFF_LHOLD_HI 5'h08
`define DTC_OFF_LHOLD_LO 5'h0C
`define DTC_OFF_RHOLD_HI 5'h10
`define DTC_OFF_RHOLD_LO 5'h14
`define DTC_OFF_DOUT 5'h18

// Channel window select and shared registers
`define DTC_CH_BIT 5
`define DTC_WIN_HI 7
`define DTC_WIN_LO 6
`define DTC_WIN_CH 2'h0
`define DTC_ADDR_SOFTWARE_TRIGGER_SOURCE 8'h40

// Control register fields
`define DTC_CTRL_EN 0
`define DTC_CTRL_OUTPUT_BUFFER_OFF 1
`define DTC_CTRL_TEN 2
`define DTC_CTRL_TRIGGER_SELECT_LO 3
`define DTC_CTRL_TRIGGER_SELECT_HI 5
`define DTC_CTRL_ACTIVE 8

// Trigger select codes
`define DTC_TRIGGER_SELECT_TIM_A 3'h0
`define DTC_TRIGGER_SELECT_TIM_B 3'h1
`define DTC_TRIGGER_SELECT_PIN 3'h2
`define DTC_TRIGGER_SELECT_SW 3'h7
`define DTC_TRIGGER_SELECT_RESET 3'h0

// Synchronised trigger source indices
`define DTC_SRC_TIM_A 0
`define DTC_SRC_TIM_B 1
`define DTC_SRC_PIN 2
`define DTC_NUM_SRC 3

// Reset values
`define DTC_HOLD_RESET 12'h000
`define DTC_NIB_ZERO 4'h0
`define DTC_WORD_ZERO 32'h00000000

// Wake-up delay after channel enable
`define DTC_CLK_PERIOD_NS 100
`define DTC_T_WAKEUP_NS 10000
`define DTC_WAKE_CYCLES ((`DTC_T_WAKEUP_NS + `DTC_CLK_PERIOD_NS - 1) / `DTC_CLK_PERIOD_NS)
`define DTC_WAKE_W 8

`endif

// file: verilog/dtc_trig_sync.v
// Two-stage synchroniser and rising-edge detector for hardware trigger sources
`default_nettype none
`include "dtc_consts.vh"

module dtc_trig_sync (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // Raw trigger sources
    input wire [`DTC_NUM_SRC-1:0] i_trig,
    // One-cycle rising-edge pulses
    output reg [`DTC_NUM_SRC-1:0] o_rise
);

    reg [`DTC_NUM_SRC-1:0] sync_a;
    reg [`DTC_NUM_SRC-1:0] sync_b;
    reg [`DTC_NUM_SRC-1:0] sync_prev;

    genvar s;
    generate
        for (s = 0; s < `DTC_NUM_SRC; s = s + 1) begin : g_src
            // Only sync_b reads sync_a; the edge detector looks at later stages
            always @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    sync_a[s] <= 1'b0;
                    sync_b[s] <= 1'b0;
                    sync_prev[s] <= 1'b0;
                    o_rise[s] <= 1'b0;
                end else begin
                    sync_a[s] <= i_trig[s];
                    sync_b[s] <= sync_a[s];
                    sync_prev[s] <= sync_b[s];
                    o_rise[s] <= sync_b[s] & ~sync_prev[s];
                end
            end
        end
    endgenerate

endmodule // dtc_trig_sync

`default_nettype wire

// file: verilog/dtc_top.v
// Two-channel converter data formatting and trigger control with an APB slave
//
// Summary of operation
// - Each channel has a control bit switching its output buffer off.
// - Eight-bit holding byte becomes conversion bits 11 to 4.
// - Left-aligned: high byte gives bits 11:4, low byte bits 7:4 give 3:0.
// - Right-aligned: high byte bits 3:0 give 11:8, low byte gives 7:0.
// - Conversion starts by copying holding data into the output data pair.
// - Triggers off: writing the eight-bit holding register transfers at once.
// - Triggers off, 12-bit data: low-byte write transfers, high-byte write does not.
// - Triggers on: transfer happens only on the selected trigger event.
// - Select 000 timer A, 001 timer B, 010 pin, 111 software; rest reserved.
// - Software sets its trigger bit; device then starts the conversion.
// - Device clears the software trigger bit once output data is loaded.
// - Timer and pin triggers pass two-stage sync; rising edge only triggers.
// - Trigger select cannot change while the channel is enabled.
// - Conversions only after enable plus a wake-up delay.
`default_nettype none
`include "dtc_consts.vh"

module dtc_top (
    // Clock and reset
    input wire i_clk,
    input wire i_rstn,
    // APB slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire o_pready,
    output reg [31:0] o_prdata,
    output reg o_pslverr,
    // Trigger sources
    input wire i_timer_a_trigger_out,
    input wire i_timer_b_trigger_out,
    input wire i_external_trigger_pin,
    // Converter side, channel 0 in the low half
    output wire [23:0] o_output_data_pair,
    output wire [1:0] o_output_buffer_off,
    output wire [1:0] o_channel_enable,
    output wire [1:0] o_channel_active
);

    localparam NCH = 2;
    localparam integer WAKE_LAST = `DTC_WAKE_CYCLES - 1;

    wire setup_ph;
    wire wr_acc;
    wire win_ok;
    wire sw_hit;
    wire [`DTC_NUM_SRC-1:0] rise;
    wire [NCH-1:0] load_v;
    wire [NCH-1:0] sw_sel_v;
    wire [NCH-1:0] hit_v;
    wire [NCH*32-1:0] rd_v;
    reg [NCH-1:0] sw_trig;
    reg [NCH-1:0] next_sw_trig;
    reg [31:0] next_rdata;
    reg next_err;

    // Zero wait states: read data is captured during setup
    assign o_pready = 1'b1;
    assign setup_ph = i_psel & ~i_penable;
    assign wr_acc = i_psel & i_penable & i_pwrite;
    assign win_ok = (i_paddr[`DTC_WIN_HI:`DTC_WIN_LO] == `DTC_WIN_CH);
    assign sw_hit = (i_paddr == `DTC_ADDR_SOFTWARE_TRIGGER_SOURCE);

    dtc_trig_sync u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_trig({i_external_trigger_pin, i_timer_b_trigger_out, i_timer_a_trigger_out}),
        .o_rise(rise)
    );

    genvar c;
    generate
        for (c = 0; c < NCH; c = c + 1) begin : g_ch
            wire ch_sel;
            wire [4:0] off;
            wire wr_ctrl;
            wire wr_h8;
            wire wr_lhi;
            wire wr_llo;
            wire wr_rhi;
            wire wr_rlo;
            wire data_wr;
            wire low_wr;
            reg en;
            reg output_buffer_off;
            reg trigger_enable;
            reg [2:0] trigger_select;
            reg active;
            reg [`DTC_WAKE_W-1:0] wake_cnt;
            reg [11:0] hold;
            reg [11:0] next_hold;
            reg [11:0] dout;
            reg trig_evt;
            reg [31:0] rd;

            assign ch_sel = win_ok & (i_paddr[`DTC_CH_BIT] == (c != 0));
            assign off = i_paddr[4:0];
            assign hit_v[c] = ch_sel & (off == `DTC_OFF_CTRL || off == `DTC_OFF_HOLD8 ||
                off == `DTC_OFF_LHOLD_HI || off == `DTC_OFF_LHOLD_LO ||
                off == `DTC_OFF_RHOLD_HI || off == `DTC_OFF_RHOLD_LO ||
                off == `DTC_OFF_DOUT);
            assign wr_ctrl = wr_acc & ch_sel & (off == `DTC_OFF_CTRL);
            assign wr_h8 = wr_acc & ch_sel & (off == `DTC_OFF_HOLD8);
            assign wr_lhi = wr_acc & ch_sel & (off == `DTC_OFF_LHOLD_HI);
            assign wr_llo = wr_acc & ch_sel & (off == `DTC_OFF_LHOLD_LO);
            assign wr_rhi = wr_acc & ch_sel & (off == `DTC_OFF_RHOLD_HI);
            assign wr_rlo = wr_acc & ch_sel & (off == `DTC_OFF_RHOLD_LO);
            assign data_wr = wr_h8 | wr_lhi | wr_llo | wr_rhi | wr_rlo;
            assign low_wr = wr_h8 | wr_llo | wr_rlo;

            // Holding word seen after this cycle's write, in 12-bit form
            always @* begin
                next_hold = hold;
                if (wr_h8) begin
                    next_hold = {i_pwdata[7:0], `DTC_NIB_ZERO};
                end else if (wr_lhi) begin
                    next_hold[11:4] = i_pwdata[7:0];
                end else if (wr_llo) begin
                    next_hold[3:0] = i_pwdata[7:4];
                end else if (wr_rhi) begin
                    next_hold[11:8] = i_pwdata[3:0];
                end else if (wr_rlo) begin
                    next_hold[7:0] = i_pwdata[7:0];
                end
            end

            // Selected trigger; reserved codes never fire
            always @* begin
                case (trigger_select)
                    `DTC_TRIGGER_SELECT_TIM_A: trig_evt = rise[`DTC_SRC_TIM_A];
                    `DTC_TRIGGER_SELECT_TIM_B: trig_evt = rise[`DTC_SRC_TIM_B];
                    `DTC_TRIGGER_SELECT_PIN: trig_evt = rise[`DTC_SRC_PIN];
                    `DTC_TRIGGER_SELECT_SW: trig_evt = sw_trig[c];
                    default: trig_evt = 1'b0;
                endcase
            end

            assign sw_sel_v[c] = (trigger_select == `DTC_TRIGGER_SELECT_SW);
            // Data writes only transfer with triggers off; triggers only with them on
            assign load_v[c] = active & (trigger_enable ? trig_evt : low_wr);

            always @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    en <= 1'b0;
                    output_buffer_off <= 1'b0;
                    trigger_enable <= 1'b0;
                    trigger_select <= `DTC_TRIGGER_SELECT_RESET;
                end else if (wr_ctrl) begin
                    en <= i_pwdata[`DTC_CTRL_EN];
                    output_buffer_off <= i_pwdata[`DTC_CTRL_OUTPUT_BUFFER_OFF];
                    trigger_enable <= i_pwdata[`DTC_CTRL_TEN];
                    // Select is frozen while the channel is enabled, including the write that disables it
                    if (!en) begin
                        trigger_select <= i_pwdata[`DTC_CTRL_TRIGGER_SELECT_HI:`DTC_CTRL_TRIGGER_SELECT_LO];
                    end
                end
            end

            // Wake-up counter restarts on every enable; disable drops active at once
            always @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    wake_cnt <= {`DTC_WAKE_W{1'b0}};
                    active <= 1'b0;
                end else if (!en || (wr_ctrl && !i_pwdata[`DTC_CTRL_EN])) begin
                    // Falls with the enable bit, so no load slips through a disabled cycle
                    wake_cnt <= {`DTC_WAKE_W{1'b0}};
                    active <= 1'b0;
                end else if (!active) begin
                    if (wake_cnt == WAKE_LAST[`DTC_WAKE_W-1:0]) begin
                        active <= 1'b1;
                    end else begin
                        wake_cnt <= wake_cnt + 1'b1;
                    end
                end
            end

            always @(posedge i_clk or negedge i_rstn) begin
                if (!i_rstn) begin
                    hold <= `DTC_HOLD_RESET;
                    dout <= `DTC_HOLD_RESET;
                end else begin
                    if (data_wr) begin
                        hold <= next_hold;
                    end
                    // Write-triggered loads take the value written in the same cycle
                    if (load_v[c]) begin
                        dout <= next_hold;
                    end
                end
            end

            always @* begin
                rd = `DTC_WORD_ZERO;
                if (off == `DTC_OFF_CTRL) begin
                    rd[`DTC_CTRL_EN] = en;
                    rd[`DTC_CTRL_OUTPUT_BUFFER_OFF] = output_buffer_off;
                    rd[`DTC_CTRL_TEN] = trigger_enable;
                    rd[`DTC_CTRL_TRIGGER_SELECT_HI:`DTC_CTRL_TRIGGER_SELECT_LO] = trigger_select;
                    rd[`DTC_CTRL_ACTIVE] = active;
                end else if (off == `DTC_OFF_HOLD8) begin
                    rd[7:0] = hold[11:4];
                end else if (off == `DTC_OFF_LHOLD_HI) begin
                    rd[7:0] = hold[11:4];
                end else if (off == `DTC_OFF_LHOLD_LO) begin
                    rd[7:4] = hold[3:0];
                end else if (off == `DTC_OFF_RHOLD_HI) begin
                    rd[3:0] = hold[11:8];
                end else if (off == `DTC_OFF_RHOLD_LO) begin
                    rd[7:0] = hold[7:0];
                end else if (off == `DTC_OFF_DOUT) begin
                    rd[11:0] = dout;
                end
            end

            assign rd_v[c*32 +: 32] = rd;
            assign o_output_data_pair[c*12 +: 12] = dout;
            assign o_output_buffer_off[c] = output_buffer_off;
            assign o_channel_enable[c] = en;
            assign o_channel_active[c] = active;
        end
    endgenerate

    // Software trigger bits: a new set in the clearing cycle is kept
    always @* begin
        next_sw_trig = sw_trig;
        next_sw_trig = next_sw_trig & ~(load_v & sw_sel_v);
        if (wr_acc & sw_hit) begin
            next_sw_trig = next_sw_trig | i_pwdata[NCH-1:0];
        end
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sw_trig <= {NCH{1'b0}};
        end else begin
            sw_trig <= next_sw_trig;
        end
    end

    // Read mux and unmapped-address error, registered at the setup edge
    always @* begin
        next_rdata = `DTC_WORD_ZERO;
        next_err = 1'b0;
        if (sw_hit) begin
            next_rdata[NCH-1:0] = sw_trig;
        end else if (hit_v[0]) begin
            next_rdata = rd_v[31:0];
        end else if (hit_v[1]) begin
            next_rdata = rd_v[63:32];
        end else begin
            next_err = 1'b1;
        end
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_prdata <= `DTC_WORD_ZERO;
            o_pslverr <= 1'b0;
        end else if (setup_ph) begin
            o_prdata <= next_rdata;
            o_pslverr <= next_err;
        end
    end

endmodule // dtc_top

`default_nettype wire

// file: dv/dtc_chk.sv
// Assertion checker for the converter data and trigger control block
`default_nettype none
module dtc_chk (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire logic i_timer_a_trigger_out,
    input wire logic i_timer_b_trigger_out,
    input wire logic i_external_trigger_pin,
    input wire logic [23:0] o_output_data_pair,
    input wire logic [1:0] o_output_buffer_off,
    input wire logic [1:0] o_channel_enable,
    input wire logic [1:0] o_channel_active
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic acc = i_psel && i_penable && i_pwrite;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    sequence s_ctrl_wr;
        i_psel && !i_penable ##1 acc && i_paddr == 8'h00;
    endsequence
    AST_OUTPUT_BUFFER_OFF: assert property (s_ctrl_wr |=> o_output_buffer_off[0] == $past(i_pwdata[1]))
        else $error("buffer off bit not taken from control write");
    AST_WAKE: assert property ($rose(o_channel_enable[0]) |-> !o_channel_active[0] [*8])
        else $error("channel active too soon after enable");
    AST_ACTEN: assert property (o_channel_active[0] |-> o_channel_enable[0])
        else $error("channel active while disabled");
    AST_LATE: assert property ($rose(o_channel_active[0]) |-> $past(o_channel_enable[0], 95))
        else $error("channel active without full wake-up");
    AST_IDLE: assert property (!o_channel_active[0] |=> $stable(o_output_data_pair[11:0]))
        else $error("output data moved while channel inactive");
    // A pending software bit may also fire when the channel wakes up
    AST_CAUSE: assert property ($changed(o_output_data_pair[11:0]) |-> $past(acc)
        || $past(acc, 2) || ($past(o_channel_active[0]) && !$past(o_channel_active[0], 3))
        || ($past(i_timer_a_trigger_out, 4) && !$past(i_timer_a_trigger_out, 5))
        || ($past(i_timer_b_trigger_out, 4) && !$past(i_timer_b_trigger_out, 5))
        || ($past(i_external_trigger_pin, 4) && !$past(i_external_trigger_pin, 5)))
        else $error("output data changed with no cause");
    AST_ERR: assert property (i_psel && !i_penable && i_paddr == 8'hFC |=> o_pslverr)
        else $error("no error for unmapped address");
    AST_PRD: assert property (i_psel && i_penable |=> $stable(o_prdata))
        else $error("read data moved after access");
endmodule // dtc_chk
bind dtc_top dtc_chk u_chk (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(i_psel),
    .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_timer_a_trigger_out(i_timer_a_trigger_out),
    .i_timer_b_trigger_out(i_timer_b_trigger_out),
    .i_external_trigger_pin(i_external_trigger_pin), .o_output_data_pair(o_output_data_pair),
    .o_output_buffer_off(o_output_buffer_off), .o_channel_enable(o_channel_enable),
    .o_channel_active(o_channel_active));
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the converter data and trigger control block
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic rerr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] rd;
    logic [2:0] trg = 3'h0;
    logic [2:0] c;
    logic [7:0] v;
    logic [11:0] last;
    logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3};
    wire pready;
    wire perr;
    wire [31:0] prdata;
    wire [23:0] dout;
    wire [1:0] output_buffer_off;
    wire [1:0] en;
    wire [1:0] act;
    int err_count = 0;
    int check_count = 0;

    always #50 i_clk = ~i_clk;

    dtc_top u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(perr), .i_timer_a_trigger_out(trg[0]),
        .i_timer_b_trigger_out(trg[1]), .i_external_trigger_pin(trg[2]),
        .o_output_data_pair(dout), .o_output_buffer_off(output_buffer_off), .o_channel_enable(en),
        .o_channel_active(act));

    task automatic conclude;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge i_clk);
        {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge i_clk);
        pen <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_count++;
            conclude();
        end
        rd = prdata;
        rerr = perr;
        {psel, pen} <= 2'b00;
    endtask

    // Trigger held for several cycles so the synchroniser surely sees it
    task automatic pulse(input logic [2:0] m);
        @(posedge i_clk);
        trg <= m;
        repeat (4) @(posedge i_clk);
        trg <= 3'h0;
        repeat (6) @(posedge i_clk);
    endtask

    task automatic expect_out(input string n, input logic [11:0] e);
        repeat (3) @(posedge i_clk);
        chk(n, {20'h0, dout[11:0]}, {20'h0, e});
        apb(1'b0, 8'h18, 32'h0);
        chk(n, rd, {20'h0, e});
    endtask

    initial begin
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        apb(1'b0, 8'hFC, 32'h0);
        chk("unmapped", {31'h0, rerr}, 32'h1);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b1, 8'h24, 32'hAB);
        chk("output_buffer_off", {30'h0, output_buffer_off}, 32'h1);
        chk("early", {30'h0, act}, 32'h0);
        repeat (110) @(posedge i_clk);
        chk("active", {28'h0, en, act}, 32'h5);
        chk("ch1 idle", {20'h0, dout[23:12]}, 32'h0);
        apb(1'b1, 8'h04, 32'hA5);
        expect_out("fmt8", 12'hA50);
        apb(1'b1, 8'h08, 32'h12);
        expect_out("hi only", 12'hA50);
        apb(1'b1, 8'h0C, 32'h3F);
        expect_out("left", 12'h123);
        apb(1'b1, 8'h10, 32'hF4);
        apb(1'b1, 8'h14, 32'h56);
        expect_out("right", 12'h456);
        last = 12'h456;
        for (int i = 0; i < 5; i++) begin
            c = codes[i];
            v = {i[3:0], 4'h9};
            apb(1'b1, 8'h00, 32'h0);
            apb(1'b1, 8'h00, {26'h0, c, 3'h4});
            apb(1'b1, 8'h00, {26'h0, c, 3'h5});
            apb(1'b1, 8'h00, {26'h0, ~c, 3'h5});
            repeat (110) @(posedge i_clk);
            apb(1'b0, 8'h00, 32'h0);
            chk("ctrl", rd, {23'h0, 1'b1, 2'h0, c, 3'h5});
            apb(1'b1, 8'h04, {24'h0, v});
            expect_out("held", last);
            pulse(~((c < 3) ? (3'h1 << c) : 3'h0));
            expect_out("other source", last);
            if (c < 3)
                pulse(3'h1 << c);
            else
                apb(1'b1, 8'h40, 32'h1);
            if (c != 3)
                last = {v, 4'h0};
            expect_out("trigger", last);
            apb(1'b0, 8'h40, 32'h0);
            chk("sw bit", rd, {31'h0, c == 3});
        end
        conclude();
    end
endmodule // tb_top
`default_nettype wire
